// File: logic/dcx_timer.sv
// Purpose: software-loadable down counter raising a counter exception to the core
// Assumes: tick_i is an asynchronous time-base tick level from a pin; core
//          inputs are synchronous to clk_sys_i
// Notes:   registers over APB with zero wait states; one level interrupt output
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps

// Functional notes
// - take only when pending, unblocked, interrupts enabled
// - count down, request on passing zero
// - request pends until taken, taking clears it
// - counter and time base share one tick
// - reading count has no side effect
// - software write replaces whole count
// - msb rising from 0 to 1 requests
// - several requests merge into one exception
// - software write raising msb also requests
// - save next instruction address on entry
// - saved state: copy bit 0, clear fields
// - saved state copies the listed state fields
// - further state bits may also be saved
// - fetch resumes at vector offset from base
// - wide-mode-on-interrupt copied into wide mode
module dcx_timer
  import dcx_pkg::*;
#(
  parameter int unsigned CNT_WIDTH        = 32,
  parameter logic        WIDE_ON_INT_IMPL = 1'b1,
  parameter logic [63:0] EXTRA_COPY_MASK  = 64'h0000_0000_0000_0000,
  parameter logic [63:0] VEC_BASE_LOW     = 64'h0000_0000_0000_0000,
  parameter logic [63:0] VEC_BASE_HIGH    = 64'h0000_0000_0010_0000
) (
  input  wire logic              clk_sys_i,
  input  wire logic              arst_n_i,
  input  wire logic              ce_i,
  // apb slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [APB_AW-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // time base
  input  wire logic              tick_i,
  output logic                   timebase_tick_o,
  // core side
  input  wire logic [63:0]       machine_state_word_i,
  input  wire logic [63:0]       next_insn_addr_i,
  input  wire logic              higher_prio_exc_i,
  output logic                   exc_take_o,
  output logic      [63:0]       save_restore_address_o,
  output logic      [63:0]       save_restore_state_o,
  output logic      [63:0]       machine_state_word_o,
  output logic      [63:0]       fetch_address_o,
  output logic                   irq_o
);

  initial begin
    if (CNT_WIDTH < 2 || CNT_WIDTH > 32) begin
      $error("CNT_WIDTH must lie between 2 and 32");
    end
  end

  localparam int unsigned MSB = CNT_WIDTH - 1;

  // ----------------------------------------------------------------
  // tick synchroniser and edge detect
  // ----------------------------------------------------------------
  logic tick_s1_reg;
  logic tick_s2_reg;
  logic tick_s3_reg;
  wire  tick_pulse = tick_s2_reg & ~tick_s3_reg;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_s1_reg <= 1'b0;
      tick_s2_reg <= 1'b0;
      tick_s3_reg <= 1'b0;
    end else if (ce_i) begin
      tick_s1_reg <= tick_i;
      tick_s2_reg <= tick_s1_reg;
      tick_s3_reg <= tick_s2_reg;
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire apb_setup  = psel_i & ~penable_i;
  wire apb_access = psel_i & penable_i & pready_o;
  wire hit_count  = (paddr_i == ADDR_COUNT);
  wire hit_status = (paddr_i == ADDR_STATUS);
  wire hit_mask   = (paddr_i == ADDR_MASK);
  wire hit_snap   = (paddr_i == ADDR_SNAPSHOT);
  wire unmapped   = ~(hit_count | hit_status | hit_mask | hit_snap);
  wire wr_count   = apb_access & pwrite_i & hit_count;
  wire wr_status  = apb_access & pwrite_i & hit_status;
  wire wr_mask    = apb_access & pwrite_i & hit_mask;

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  logic [CNT_WIDTH-1:0] count_reg;
  logic [CNT_WIDTH-1:0] count_next;
  logic                 pend_reg;
  logic                 mask_reg;

  // a write in the same cycle as a tick wins: software owns the value
  assign count_next = wr_count   ? pwdata_i[CNT_WIDTH-1:0] :
                      tick_pulse ? count_reg - 1'b1 :
                                   count_reg;

  // msb rise from either source; a wrap through zero is such a rise
  wire msb_rise = ~count_reg[MSB] & count_next[MSB];

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_reg <= COUNT_RESET[CNT_WIDTH-1:0];
    end else if (ce_i) begin
      count_reg <= count_next;
    end
  end

  // ----------------------------------------------------------------
  // pending request, taken by the core
  // ----------------------------------------------------------------
  wire msw_ee   = machine_state_word_i[be64(MSW_EE)];
  wire take_now = pend_reg & ~higher_prio_exc_i & msw_ee;
  wire pend_w1c = wr_status & pwdata_i[STAT_PEND_BIT];

  // a new rise in the cycle of a take or clear keeps the request alive
  wire pend_next = msb_rise | (pend_reg & ~take_now & ~pend_w1c);
  wire mask_next = wr_mask ? pwdata_i[STAT_PEND_BIT] : mask_reg;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_reg <= PEND_RESET;
      mask_reg <= MASK_RESET;
      irq_o    <= 1'b0;
    end else if (ce_i) begin
      pend_reg <= pend_next;
      mask_reg <= mask_next;
      irq_o    <= pend_next & mask_next;
    end
  end

  // ----------------------------------------------------------------
  // entry state
  // ----------------------------------------------------------------
  logic [63:0] srs_build;
  logic [63:0] msw_build;

  dcx_state_builder #(
    .WIDE_ON_INT_IMPL (WIDE_ON_INT_IMPL),
    .EXTRA_COPY_MASK  (EXTRA_COPY_MASK)
  ) u_builder (
    .msw_i     (machine_state_word_i),
    .srs_o     (srs_build),
    .msw_new_o (msw_build)
  );

  // vector prefix is left unchanged on entry, so the old one selects the base
  wire [63:0] vec_base = machine_state_word_i[be64(MSW_VEC_SEL)] ? VEC_BASE_HIGH
                                                                  : VEC_BASE_LOW;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      exc_take_o             <= 1'b0;
      save_restore_address_o <= 64'h0;
      save_restore_state_o   <= 64'h0;
      machine_state_word_o   <= 64'h0;
      fetch_address_o        <= 64'h0;
      timebase_tick_o        <= 1'b0;
    end else if (ce_i) begin
      exc_take_o      <= take_now;
      timebase_tick_o <= tick_pulse;
      if (take_now) begin
        save_restore_address_o <= next_insn_addr_i;
        save_restore_state_o   <= srs_build;
        machine_state_word_o   <= msw_build;
        fetch_address_o        <= vec_base | VEC_OFFSET;
      end
    end
  end

  // ----------------------------------------------------------------
  // apb response, zero wait states
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [31:0] snap_reg;

  always_comb begin
    rd_mux = 32'h0;
    if (hit_count) begin
      rd_mux[CNT_WIDTH-1:0] = count_reg;
    end else if (hit_status) begin
      rd_mux[STAT_PEND_BIT] = pend_reg;
    end else if (hit_mask) begin
      rd_mux[STAT_PEND_BIT] = mask_reg;
    end else if (hit_snap) begin
      rd_mux = snap_reg;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0;
      snap_reg  <= 32'h0;
    end else if (ce_i) begin
      pready_o  <= apb_setup;
      pslverr_o <= apb_setup & unmapped;
      if (apb_setup) begin
        prdata_o <= pwrite_i ? 32'h0 : rd_mux;
      end
      // low word of the last saved address, for software diagnosis
      if (take_now) begin
        snap_reg <= next_insn_addr_i[31:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  AST_TAKE_COND: assert property (
    $rose(exc_take_o) |-> $past(pend_reg) && $past(msw_ee) && !$past(higher_prio_exc_i))
    else $error("exception taken without its conditions");

  AST_WRAP_REQ: assert property (
    ce_i && tick_pulse && !wr_count && count_reg == '0
      |=> count_reg == {CNT_WIDTH{1'b1}} && pend_reg)
    else $error("wrap through zero did not request");

  AST_PEND_HOLD: assert property (
    ce_i && pend_reg && !take_now && !pend_w1c |=> pend_reg)
    else $error("pending request lost before being taken");

  AST_TAKE_CLEAR: assert property (
    ce_i && take_now && !msb_rise ##1 ce_i |-> !pend_reg ##1 !exc_take_o)
    else $error("taking did not cancel the request");

  AST_TB_SAME_TICK: assert property (
    ce_i && tick_pulse && !wr_count |=> timebase_tick_o && count_reg == $past(count_reg) - 1'b1)
    else $error("counter and time base out of step");

  AST_READ_NOSIDE: assert property (
    ce_i && apb_access && !pwrite_i && !tick_pulse && !take_now
      |=> $stable(count_reg) && $stable(pend_reg))
    else $error("count read disturbed the counter");

  AST_WRITE_LOAD: assert property (
    ce_i && wr_count |=> count_reg == $past(pwdata_i[CNT_WIDTH-1:0]))
    else $error("software write not loaded");

  AST_RISE_REQ: assert property (
    ce_i && !count_reg[MSB] ##1 count_reg[MSB] && $past(ce_i) |-> pend_reg)
    else $error("msb rise did not request");

  AST_SINGLE_TAKE: assert property (
    ce_i && take_now && !msb_rise ##1 ce_i |=> !exc_take_o)
    else $error("merged requests delivered twice");

  AST_SAVE_ADDR: assert property (
    ce_i && take_now |=> save_restore_address_o == $past(next_insn_addr_i))
    else $error("save address wrong");

  AST_SAVE_STATE: assert property (
    ce_i && take_now |=> (save_restore_state_o & SRS_CLEAR_MASK) == 64'h0 &&
      save_restore_state_o[be64(0)] == $past(machine_state_word_i[be64(0)]))
    else $error("saved state fields wrong");

  AST_VECTOR: assert property (
    ce_i && take_now |=> fetch_address_o[15:0] == VEC_OFFSET[15:0])
    else $error("vector offset wrong");

  // ----------------------------------------------------------------
  // entry and counting checks
  // ----------------------------------------------------------------
  AST_NO_EE_NO_TAKE: assert property (
    ce_i && !msw_ee |=> !exc_take_o)
    else $error("exception taken with interrupts disabled");

  AST_BLOCKED_NO_TAKE: assert property (
    ce_i && higher_prio_exc_i |=> !exc_take_o)
    else $error("exception taken under a higher priority one");

  AST_TICK_ONLY: assert property (
    ce_i && !tick_pulse |=> !timebase_tick_o)
    else $error("time base pulse without a tick");

  AST_IDLE_HOLD: assert property (
    ce_i && !tick_pulse && !wr_count |=> $stable(count_reg))
    else $error("count moved without tick or write");

  AST_MERGE_RISE: assert property (
    ce_i && pend_reg && msb_rise |=> pend_reg)
    else $error("second request dropped the pending one");

  AST_SW_RISE_REQ: assert property (
    ce_i && wr_count && !count_reg[MSB] && pwdata_i[MSB] |=> pend_reg)
    else $error("software msb rise did not request");

  AST_ADDR_HOLD: assert property (
    ce_i && !take_now |=> $stable(save_restore_address_o))
    else $error("save address changed without a take");

  AST_STATE_HOLD: assert property (
    ce_i && !take_now |=> $stable(save_restore_state_o))
    else $error("saved state changed without a take");

  AST_SAVE_COPY: assert property (
    ce_i && take_now |=> (save_restore_state_o & SRS_COPY_MASK) ==
      ($past(machine_state_word_i) & SRS_COPY_MASK))
    else $error("saved state copy fields wrong");

  AST_SAVE_EXTRA: assert property (
    ce_i && take_now |=> (save_restore_state_o & ~(SRS_COPY_MASK | EXTRA_COPY_MASK)) == 64'h0)
    else $error("saved state holds bits not chosen for copy");

  AST_BASE_SEL: assert property (
    ce_i && take_now |=> fetch_address_o == (($past(machine_state_word_i[be64(MSW_VEC_SEL)]) ?
      VEC_BASE_HIGH : VEC_BASE_LOW) | VEC_OFFSET))
    else $error("vector base selection wrong");

  AST_WIDE_COPY: assert property (
    ce_i && take_now && WIDE_ON_INT_IMPL |=> machine_state_word_o[be64(MSW_WIDE_MODE)] ==
      $past(machine_state_word_i[be64(MSW_WIDE_ON_I)]))
    else $error("wide mode not taken from its on-interrupt bit");

  AST_NEW_STATE: assert property (
    ce_i && take_now |=> !machine_state_word_o[be64(MSW_EE)] &&
      !machine_state_word_o[be64(MSW_PRIV)] &&
      machine_state_word_o[be64(MSW_LE)] == $past(machine_state_word_i[be64(MSW_ILE)]))
    else $error("new machine state wrong");

endmodule

// File: logic/dcx_pkg.sv
// Purpose: constants shared by the down-counter exception timer files
// Assumes: big-endian bit numbering of the 64-bit machine state word (bit 0 = msb)
// Notes:   positions are given as architectural bit numbers, converted by be64()
package dcx_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned 32-bit word each)
  // ----------------------------------------------------------------
  localparam int unsigned APB_AW        = 12;
  localparam logic [11:0] ADDR_COUNT    = 12'h000;
  localparam logic [11:0] ADDR_STATUS   = 12'h004;
  localparam logic [11:0] ADDR_MASK     = 12'h008;
  localparam logic [11:0] ADDR_SNAPSHOT = 12'h00c;

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [31:0] COUNT_RESET   = 32'h0000_0000;
  localparam logic        PEND_RESET    = 1'b0;
  localparam logic        MASK_RESET    = 1'b0;
  localparam int unsigned STAT_PEND_BIT = 0;

  // machine state word fields, architectural numbering
  localparam int unsigned MSW_WIDE_MODE = 0;
  localparam int unsigned MSW_WIDE_ON_I = 2;
  localparam int unsigned MSW_POW       = 45;
  localparam int unsigned MSW_ILE       = 47;
  localparam int unsigned MSW_EE        = 48;
  localparam int unsigned MSW_PRIV      = 49;
  localparam int unsigned MSW_FP        = 50;
  localparam int unsigned MSW_FE0       = 52;
  localparam int unsigned MSW_SE        = 53;
  localparam int unsigned MSW_BE        = 54;
  localparam int unsigned MSW_FE1       = 55;
  localparam int unsigned MSW_VEC_SEL   = 57;
  localparam int unsigned MSW_IR        = 58;
  localparam int unsigned MSW_DR        = 59;
  localparam int unsigned MSW_RI        = 62;
  localparam int unsigned MSW_LE        = 63;

  // save/restore state: copied and cleared fields, as masks in vector bit order (bit 63 = architectural bit 0)
  localparam logic [63:0] SRS_COPY_MASK  = 64'h8000_0000_0000_0000 |
                                           64'h0000_0000_0000_ff00 |
                                           64'h0000_0000_0000_0070 |
                                           64'h0000_0000_0000_0003;
  localparam logic [63:0] SRS_CLEAR_MASK = 64'h0000_0000_7800_0000 |
                                           64'h0000_0000_003f_0000;

  // exception vector
  localparam logic [63:0] VEC_OFFSET    = 64'h0000_0000_0000_0900;

  function automatic int unsigned be64(input int unsigned n);
    return 63 - n;
  endfunction

endpackage

// File: logic/dcx_state_builder.sv
// Purpose: builds the saved state word and the new machine state on entry
// Assumes: msw_i is the machine state word seen in the cycle of entry
// Notes:   purely combinational; the caller registers the results
`timescale 1ns/1ps
module dcx_state_builder
  import dcx_pkg::*;
#(
  parameter logic        WIDE_ON_INT_IMPL = 1'b1,
  parameter logic [63:0] EXTRA_COPY_MASK  = 64'h0000_0000_0000_0000
) (
  input  wire logic [63:0] msw_i,
  output logic      [63:0] srs_o,
  output logic      [63:0] msw_new_o
);

  // extra copies may never reach the bits that must read cleared
  localparam logic [63:0] COPY_ALL = (SRS_COPY_MASK | EXTRA_COPY_MASK) & ~SRS_CLEAR_MASK;

  initial begin
    if ((EXTRA_COPY_MASK & SRS_CLEAR_MASK) != 64'h0) begin
      $error("extra copy mask overlaps cleared fields");
    end
  end

  // ----------------------------------------------------------------
  // saved state
  // ----------------------------------------------------------------
  assign srs_o = msw_i & COPY_ALL;

  // ----------------------------------------------------------------
  // new machine state
  // ----------------------------------------------------------------
  always_comb begin
    msw_new_o = msw_i;
    msw_new_o[be64(MSW_POW)] = 1'b0;
    msw_new_o[be64(MSW_EE)]  = 1'b0;
    msw_new_o[be64(MSW_PRIV)] = 1'b0;
    msw_new_o[be64(MSW_FP)]  = 1'b0;
    msw_new_o[be64(MSW_FE0)] = 1'b0;
    msw_new_o[be64(MSW_SE)]  = 1'b0;
    msw_new_o[be64(MSW_BE)]  = 1'b0;
    msw_new_o[be64(MSW_FE1)] = 1'b0;
    msw_new_o[be64(MSW_IR)]  = 1'b0;
    msw_new_o[be64(MSW_DR)]  = 1'b0;
    msw_new_o[be64(MSW_RI)]  = 1'b0;
    msw_new_o[be64(MSW_LE)]  = msw_i[be64(MSW_ILE)];
    if (WIDE_ON_INT_IMPL) begin
      msw_new_o[be64(MSW_WIDE_MODE)] = msw_i[be64(MSW_WIDE_ON_I)];
    end
  end

endmodule

// File: testbench/dcx_core_model.sv
// Purpose: core model on the far side of the down-counter timer
// Assumes: load requests come from the bench just after a rising edge
// Notes:   walks the next address by 4, jumps to the vector on a take
`timescale 1ns/1ps
module dcx_core_model (
  input  wire logic        clk_sys_i,
  input  wire logic        arst_n_i,
  input  wire logic        ld_i,
  input  wire logic [63:0] ld_msw_i,
  input  wire logic [63:0] ld_nia_i,
  input  wire logic        take_i,
  input  wire logic [63:0] msw_new_i,
  input  wire logic [63:0] fetch_i,
  output logic      [63:0] msw_o,
  output logic      [63:0] nia_o
);
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      msw_o <= 64'h0;
      nia_o <= 64'h0;
    end else if (ld_i) begin
      msw_o <= ld_msw_i;
      nia_o <= ld_nia_i;
    end else if (take_i) begin
      // adopt the new state so a cleared enable stops a second take
      msw_o <= msw_new_i;
      nia_o <= fetch_i;
    end else begin
      nia_o <= nia_o + 64'h4;
    end
  end
endmodule

// File: testbench/dcx_timer_tb.sv
// Purpose: self-checking bench for the down-counter exception timer
// Assumes: zero-wait apb slave, tick seen a few clocks after its rise
// Notes:   expectations come from a small model kept in the bench
`timescale 1ns/1ps
module dcx_timer_tb;
  import dcx_pkg::*;
  localparam logic [63:0] VB_LO = 64'h0000_0000_0000_0000;
  localparam logic [63:0] VB_HI = 64'h0000_0000_0030_0000;
  localparam int CLR[11] = '{45, 48, 49, 50, 52, 53, 54, 55, 58, 59, 62};
  logic        clk_sys_i, arst_n_i, psel, pen, pwr, tick, blk, ld, rdy, err;
  logic        tbt, take, irq, er, e_pend, e_mask;
  logic [11:0] paddr;
  logic [31:0] pwd, prd, rd, e_cnt;
  logic [63:0] msw, nia, sra, srs, msw_n, fetch, ld_msw, ld_nia, p_msw, p_nia, v;
  logic [15:0] seed;
  int          err_total, n_tests, n_tb, n_take, n_tick, n;

  dcx_timer #(.VEC_BASE_LOW(VB_LO), .VEC_BASE_HIGH(VB_HI)) dcx_timer_inst (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ce_i(1'b1), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd),
    .prdata_o(prd), .pready_o(rdy), .pslverr_o(err), .tick_i(tick),
    .timebase_tick_o(tbt), .machine_state_word_i(msw), .next_insn_addr_i(nia),
    .higher_prio_exc_i(blk), .exc_take_o(take), .save_restore_address_o(sra),
    .save_restore_state_o(srs), .machine_state_word_o(msw_n),
    .fetch_address_o(fetch), .irq_o(irq));
  dcx_core_model dcx_core_model_inst (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ld_i(ld), .ld_msw_i(ld_msw),
    .ld_nia_i(ld_nia), .take_i(take), .msw_new_i(msw_n), .fetch_i(fetch),
    .msw_o(msw), .nia_o(nia));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    p_msw <= msw;
    p_nia <= nia;
    if (take === 1'b1) n_take++;
    if (tbt === 1'b1) n_tb++;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic rnd(output logic [63:0] r);
    repeat (4) begin
      seed = lfsr(seed);
      r = {r[47:0], seed};
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk_sys_i);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (rdy !== 1'b1 && k < 20);
    rd = prd;
    er = err;
    psel <= 1'b0;
    pen <= 1'b0;
    if (k >= 20) chk("pready", 64'h1, 64'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    if (a == ADDR_COUNT && !e_cnt[31] && d[31]) e_pend = 1'b1;
    if (a == ADDR_COUNT) e_cnt = d;
    if (a == ADDR_STATUS && d[0]) e_pend = 1'b0;
    if (a == ADDR_MASK) e_mask = d[0];
  endtask
  task automatic do_tick(input int k);
    logic [31:0] nx;
    repeat (k) begin
      @(posedge clk_sys_i);
      tick <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      tick <= 1'b0;
      repeat (5) @(posedge clk_sys_i);
      n_tick++;
      nx = e_cnt - 32'h1;
      if (!e_cnt[31] && nx[31]) e_pend = 1'b1;
      e_cnt = nx;
    end
  endtask
  task automatic chk_state();
    apb(1'b0, ADDR_COUNT, 32'h0);
    chk("count", {32'h0, e_cnt}, {32'h0, rd});
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("pending", {63'h0, e_pend}, {63'h0, rd[0]});
    @(negedge clk_sys_i);
    chk("irq", {63'h0, e_pend & e_mask}, {63'h0, irq});
    chk("ticks", n_tick, n_tb);
  endtask
  function automatic logic [63:0] exp_srs(input logic [63:0] m);
    logic [63:0] r;
    r = 64'h0;
    for (int i = 0; i < 64; i++)
      if (i == 0 || (i >= 48 && i != 56 && i != 60 && i != 61)) r[63-i] = m[63-i];
    return r;
  endfunction
  function automatic logic [63:0] exp_msw(input logic [63:0] m);
    logic [63:0] r;
    r = m;
    foreach (CLR[i]) r[63-CLR[i]] = 1'b0;
    r[0] = m[16];
    r[63] = m[61];
    return r;
  endfunction

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    #100us;
    err_total++;
    $display("ERROR watchdog expected done seen hang");
    end_sim();
  end
  initial begin
    {arst_n_i, psel, pen, pwr, tick, blk, ld, e_pend, e_mask} = '0;
    paddr = '0;
    pwd = '0;
    ld_msw = '0;
    ld_nia = '0;
    e_cnt = '0;
    seed = 16'ha833;
    repeat (5) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    apb(1'b0, ADDR_MASK, 32'h0);
    chk("mask", 64'h0, {32'h0, rd});
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", 64'h1_0000_0000, {31'h0, er, rd});
    chk_state();
    $display("test reset done");
    rnd(v);
    wr(ADDR_COUNT, v[31:0] & 32'h7fff_ffff);
    chk_state();
    chk_state();
    $display("test load done");
    wr(ADDR_COUNT, 32'h0000_0002);
    do_tick(3);
    chk_state();
    wr(ADDR_COUNT, 32'h0000_0001);
    do_tick(2);
    chk_state();
    chk("no take", 64'h0, n_take);
    wr(ADDR_MASK, 32'h0000_0001);
    chk_state();
    wr(ADDR_STATUS, 32'h0000_0001);
    chk_state();
    $display("test count done");
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_COUNT, 32'h0000_0010);
      wr(ADDR_COUNT, 32'h8000_0005);
      chk_state();
      rnd(v);
      ld_nia <= {v[63:2], 2'b00};
      rnd(v);
      ld_msw <= v | 64'h0000_0000_0000_8000;
      blk <= 1'b1;
      ld <= 1'b1;
      @(posedge clk_sys_i);
      ld <= 1'b0;
      repeat (5) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      chk("blocked", k, n_take);
      @(posedge clk_sys_i);
      blk <= 1'b0;
      n = 0;
      while (take !== 1'b1 && n < 10) begin
        @(negedge clk_sys_i);
        n++;
      end
      chk("take", 64'h1, {63'h0, take});
      e_pend = 1'b0;
      v = p_nia;
      chk("sra", p_nia, sra);
      chk("srs", exp_srs(p_msw), srs);
      chk("msw", exp_msw(p_msw), msw_n);
      chk("fetch", (p_msw[6] ? VB_HI : VB_LO) | 64'h0000_0000_0000_0900, fetch);
      apb(1'b0, ADDR_SNAPSHOT, 32'h0);
      chk("snapshot", {32'h0, v[31:0]}, {32'h0, rd});
      chk_state();
      chk("takes", k + 1, n_take);
      $display("test take %0d done", k);
    end
    end_sim();
  end
endmodule
